// file: logic/system_tick_timer.sv
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
// Summary of operation
// - the zero flag at bit 16 is set when the counter has reached zero since the last read.
// - a read of the control and status register clears the zero flag after returning it, unless the counter reaches zero in that same cycle.
// - bit 2 picks the count clock: 0 the external fosc/32 reference, 1 the system clock.
// - with bit 1 set, reaching zero pends the tick exception; with it clear, nothing pends.
// - setting bit 0 loads the counter from the reload value and starts; clearing it stops.
// - the 24-bit reload value is copied in each time the counter hits zero; bits 31-24 read 0.
// - the current-value register reads the live count, and any write clears it to zero.
// - a write that clears the current value also clears the zero flag.
// - calibration bit 31 reads 0 when a reference clock exists and 1 when none does.
// - calibration bit 30 reads 0 when the count gives exactly 10 ms, 1 otherwise.
// - the calibration count field reads 0xC35, the number of reference-clock ticks in 10 ms; the reload for a 10 ms period is one less.
// - after reset the control register reads zero: stopped, external reference selected.
module system_tick_timer #(
    parameter logic REF_PRESENT = 1'b1,
    parameter logic CAL_INEXACT = 1'b0
) (
    input  wire logic                                 aclk,
    input  wire logic                                 aresetn,
    input  wire logic [tick_timer_pkg::ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic [2:0]                           s_axi_awprot,
    input  wire logic                                 s_axi_awvalid,
    output logic                                      s_axi_awready,
    input  wire logic [tick_timer_pkg::DATA_W-1:0]    s_axi_wdata,
    input  wire logic [tick_timer_pkg::STRB_W-1:0]    s_axi_wstrb,
    input  wire logic                                 s_axi_wvalid,
    output logic                                      s_axi_wready,
    output logic [1:0]                                s_axi_bresp,
    output logic                                      s_axi_bvalid,
    input  wire logic                                 s_axi_bready,
    input  wire logic [tick_timer_pkg::ADDR_W-1:0]    s_axi_araddr,
    input  wire logic [2:0]                           s_axi_arprot,
    input  wire logic                                 s_axi_arvalid,
    output logic                                      s_axi_arready,
    output logic [tick_timer_pkg::DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                                s_axi_rresp,
    output logic                                      s_axi_rvalid,
    input  wire logic                                 s_axi_rready,
    input  wire logic                                 ext_ref_in,
    output logic                                      tick_exception_pend,
    output logic                                      irq
);
    import tick_timer_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [DATA_W-1:0] merge_strb(
        input logic [DATA_W-1:0] old_v,
        input logic [DATA_W-1:0] new_v,
        input logic [STRB_W-1:0] strb
    );
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_strb

    function automatic logic known_addr(input logic [ADDR_W-1:0] a);
        return (a == OFF_CTRL) || (a == OFF_RELOAD) || (a == OFF_CUR) ||
               (a == OFF_CAL) || (a == OFF_EVT) || (a == OFF_MASK);
    endfunction : known_addr

    // ****************************************************************
    // state
    // ****************************************************************
    ctrl_s                ctrl_ff;
    logic                 count_flag_ff;
    logic [COUNT_W-1:0]   reload_ff;
    logic [COUNT_W-1:0]   current_ff;
    logic                 evt_status_ff;
    logic                 evt_mask_ff;
    logic                 pend_ff;
    logic                 irq_ff;
    wr_state_e            wr_state_ff;
    logic                 aw_got_ff;
    logic                 w_got_ff;
    logic                 awready_ff;
    logic                 wready_ff;
    logic [1:0]           bresp_ff;
    logic [ADDR_W-1:0]    awaddr_ff;
    logic [DATA_W-1:0]    wdata_ff;
    logic [STRB_W-1:0]    wstrb_ff;
    logic                 arready_ff;
    logic                 rvalid_ff;
    logic [DATA_W-1:0]    rdata_ff;
    logic [1:0]           rresp_ff;
    logic                 tick;

    // ****************************************************************
    // write channel decode
    // ****************************************************************
    wire                aw_take  = s_axi_awvalid & awready_ff;
    wire                w_take   = s_axi_wvalid & wready_ff;
    wire                aw_have  = aw_got_ff | aw_take;
    wire                w_have   = w_got_ff | w_take;
    wire                wr_fire  = (wr_state_ff == WR_IDLE) & aw_have & w_have;
    wire [ADDR_W-1:0]   waddr    = aw_got_ff ? awaddr_ff : s_axi_awaddr;
    wire [DATA_W-1:0]   wdata    = w_got_ff ? wdata_ff : s_axi_wdata;
    wire [STRB_W-1:0]   wstrb    = w_got_ff ? wstrb_ff : s_axi_wstrb;
    wire                ctrl_wr  = wr_fire & (waddr == OFF_CTRL);
    wire                rel_wr   = wr_fire & (waddr == OFF_RELOAD);
    wire                cur_wr   = wr_fire & (waddr == OFF_CUR);
    wire                evt_wr   = wr_fire & (waddr == OFF_EVT);
    wire                mask_wr  = wr_fire & (waddr == OFF_MASK);
    wire [DATA_W-1:0]   ctrl_cur = {29'h0000_0000, ctrl_ff};
    wire [DATA_W-1:0]   ctrl_mrg = merge_strb(ctrl_cur, wdata, wstrb);
    wire [DATA_W-1:0]   rel_mrg  = merge_strb({8'h00, reload_ff}, wdata, wstrb);
    wire                evt_clr  = evt_wr & wstrb[0] & wdata[EVT_ZERO_POS];
    wire                mask_set = mask_wr & wstrb[0];
    // the source follows the write edge, so no stale tick of the old clock is counted
    wire                nxt_src  = ctrl_wr ? ctrl_mrg[SRC_POS] : ctrl_ff.tick_source_select;

    tick_source u_tick_source (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .ext_ref_in         (ext_ref_in),
        .tick_source_select (nxt_src),
        .tick               (tick)
    );

    // ****************************************************************
    // counter core
    // ****************************************************************
    wire                ctrl_new_en = ctrl_wr ? ctrl_mrg[ENABLE_POS] : ctrl_ff.enable;
    wire                start       = ctrl_new_en & ~ctrl_ff.enable;
    wire                run         = ctrl_ff.enable & ctrl_new_en;
    wire                step        = run & tick & ~cur_wr;
    wire                at_zero     = (current_ff == COUNT_RESET);
    wire                reach_zero  = step & (current_ff == 24'h00_0001);
    wire                ar_take     = s_axi_arvalid & arready_ff;
    wire                rd_ctrl_clr = ar_take & (s_axi_araddr == OFF_CTRL);

    wire [COUNT_W-1:0]  nxt_current =
        cur_wr ? COUNT_RESET :
        start  ? reload_ff :
        !step  ? current_ff :
        at_zero ? reload_ff :
        COUNT_W'(current_ff - 24'h00_0001);

    // the new zero event beats a same-cycle control read or event-status clear, so none is lost
    wire nxt_count_flag = reach_zero |
                          (count_flag_ff & ~rd_ctrl_clr & ~cur_wr);
    wire nxt_evt_status = reach_zero | (evt_status_ff & ~evt_clr);
    wire nxt_pend       = reach_zero & ctrl_ff.tick_exception_request;
    wire nxt_irq        = nxt_evt_status & (mask_set ? wdata[EVT_ZERO_POS] : evt_mask_ff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff       <= CTRL_RESET;
            count_flag_ff <= 1'b0;
            reload_ff     <= COUNT_RESET;
            current_ff    <= COUNT_RESET;
            evt_status_ff <= 1'b0;
            evt_mask_ff   <= 1'b0;
            pend_ff       <= 1'b0;
            irq_ff        <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                ctrl_ff <= ctrl_mrg[2:0];
            end
            if (rel_wr) begin
                reload_ff <= rel_mrg[COUNT_W-1:0];
            end
            if (mask_set) begin
                evt_mask_ff <= wdata[EVT_ZERO_POS];
            end
            current_ff    <= nxt_current;
            count_flag_ff <= nxt_count_flag;
            evt_status_ff <= nxt_evt_status;
            pend_ff       <= nxt_pend;
            irq_ff        <= nxt_irq;
        end
    end

    // ****************************************************************
    // write channel
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= WR_IDLE;
            aw_got_ff   <= 1'b0;
            w_got_ff    <= 1'b0;
            awready_ff  <= 1'b1;
            wready_ff   <= 1'b1;
            bresp_ff    <= RESP_OKAY;
            awaddr_ff   <= '0;
            wdata_ff    <= '0;
            wstrb_ff    <= '0;
        end else begin
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            case (wr_state_ff)
                WR_IDLE: begin
                    if (wr_fire) begin
                        wr_state_ff <= WR_RESP;
                        aw_got_ff   <= 1'b0;
                        w_got_ff    <= 1'b0;
                        awready_ff  <= 1'b0;
                        wready_ff   <= 1'b0;
                        bresp_ff    <= known_addr(waddr) ? RESP_OKAY : RESP_SLVERR;
                    end else begin
                        aw_got_ff  <= aw_have;
                        w_got_ff   <= w_have;
                        awready_ff <= ~aw_have;
                        wready_ff  <= ~w_have;
                    end
                end
                WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_ff <= WR_IDLE;
                        awready_ff  <= 1'b1;
                        wready_ff   <= 1'b1;
                    end
                end
                default: begin
                    wr_state_ff <= WR_IDLE;
                    awready_ff  <= 1'b1;
                    wready_ff   <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************************************
    // read channel
    // ****************************************************************
    wire [DATA_W-1:0] ctrl_rd = (DATA_W'(count_flag_ff) << FLAG_POS) | ctrl_cur;
    wire [DATA_W-1:0] cal_rd  = (DATA_W'(~REF_PRESENT) << NO_REF_POS) |
                                (DATA_W'(CAL_INEXACT) << INEXACT_POS) |
                                {8'h00, TEN_MS_COUNT};
    wire [DATA_W-1:0] rd_mux  =
        (s_axi_araddr == OFF_CTRL)   ? ctrl_rd :
        (s_axi_araddr == OFF_RELOAD) ? {8'h00, reload_ff} :
        (s_axi_araddr == OFF_CUR)    ? {8'h00, current_ff} :
        (s_axi_araddr == OFF_CAL)    ? cal_rd :
        (s_axi_araddr == OFF_EVT)    ? DATA_W'(evt_status_ff) :
        (s_axi_araddr == OFF_MASK)   ? DATA_W'(evt_mask_ff) : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= '0;
            rresp_ff   <= RESP_OKAY;
        end else if (ar_take) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rdata_ff   <= rd_mux;
            rresp_ff   <= known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    assign s_axi_awready       = awready_ff;
    assign s_axi_wready        = wready_ff;
    assign s_axi_bvalid        = wr_state_ff[1];
    assign s_axi_bresp         = bresp_ff;
    assign s_axi_arready       = arready_ff;
    assign s_axi_rvalid        = rvalid_ff;
    assign s_axi_rdata         = rdata_ff;
    assign s_axi_rresp         = rresp_ff;
    assign tick_exception_pend = pend_ff;
    assign irq                 = irq_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence read_answer;
        ##1 s_axi_rvalid;
    endsequence

    flag_set_a : assert property (reach_zero |=> count_flag_ff)
        else $error("zero reached but flag not set");
    read_clear_a : assert property (rd_ctrl_clr && !reach_zero |=> !count_flag_ff)
        else $error("control read did not clear flag");
    pend_gate_a : assert property (
        reach_zero |=> (tick_exception_pend == $past(ctrl_ff.tick_exception_request)))
        else $error("exception pend does not follow request bit");
    start_load_a : assert property (start && !cur_wr |=> current_ff == $past(reload_ff))
        else $error("enable did not load reload value");
    stopped_hold_a : assert property (!ctrl_ff.enable && !start && !cur_wr |=> $stable(current_ff))
        else $error("counter moved while disabled");
    zero_reload_a : assert property (step && at_zero |=> current_ff == $past(reload_ff))
        else $error("no reload after zero");
    count_down_a : assert property (
        step && !at_zero |=> current_ff == COUNT_W'($past(current_ff) - 24'h00_0001))
        else $error("counter did not decrement by one");
    cur_clear_a : assert property (cur_wr |=> current_ff == COUNT_RESET && !count_flag_ff)
        else $error("current write did not clear count and flag");
    cal_read_a : assert property (ar_take && s_axi_araddr == OFF_CAL |-> read_answer
        ##0 s_axi_rdata == cal_rd)
        else $error("calibration read value wrong");
    reload_rsvd_a : assert property (ar_take && s_axi_araddr == OFF_RELOAD |-> read_answer
        ##0 s_axi_rdata[31:24] == 8'h00)
        else $error("reserved reload bits not zero");
    reset_ctrl_a : assert property ($rose(aresetn) |-> ctrl_ff == CTRL_RESET && !count_flag_ff)
        else $error("control not clear after reset");

endmodule : system_tick_timer

// file: logic/tick_timer_pkg.sv
package tick_timer_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned STRB_W    = 4;
    localparam int unsigned COUNT_W   = 24;

    // ****************************************************************
    // register byte addresses
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL   = 8'h10;
    localparam logic [7:0] OFF_RELOAD = 8'h14;
    localparam logic [7:0] OFF_CUR    = 8'h18;
    localparam logic [7:0] OFF_CAL    = 8'h1C;
    localparam logic [7:0] OFF_EVT    = 8'h20;
    localparam logic [7:0] OFF_MASK   = 8'h24;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int unsigned ENABLE_POS   = 0;
    localparam int unsigned EXC_REQ_POS  = 1;
    localparam int unsigned SRC_POS      = 2;
    localparam int unsigned FLAG_POS     = 16;
    localparam int unsigned NO_REF_POS   = 31;
    localparam int unsigned INEXACT_POS  = 30;
    localparam int unsigned EVT_ZERO_POS = 0;

    // ****************************************************************
    // reset and fixed values
    // ****************************************************************
    localparam logic [2:0]         CTRL_RESET   = 3'h0;
    localparam logic [COUNT_W-1:0] COUNT_RESET  = 24'h00_0000;
    localparam logic [COUNT_W-1:0] TEN_MS_COUNT = 24'h00_0C35;
    localparam logic [1:0]         RESP_OKAY    = 2'h0;
    localparam logic [1:0]         RESP_SLVERR  = 2'h2;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic tick_source_select;
        logic tick_exception_request;
        logic enable;
    } ctrl_s;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_e;

endpackage : tick_timer_pkg

// file: logic/tick_source.sv
`timescale 1ns/1ns
module tick_source (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ext_ref_in,
    input  wire logic tick_source_select,
    output logic      tick
);
    import tick_timer_pkg::*;

    // ****************************************************************
    // reference pin synchroniser and edge detect
    // ****************************************************************
    logic ref_meta_ff;
    logic ref_sync_ff;
    logic ref_prev_ff;
    logic tick_ff;
    wire  ref_edge;

    // prev looks at the second stage only, never the metastable one
    assign ref_edge = ref_sync_ff & ~ref_prev_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_meta_ff <= 1'b0;
            ref_sync_ff <= 1'b0;
            ref_prev_ff <= 1'b0;
            tick_ff     <= 1'b0;
        end else begin
            ref_meta_ff <= ext_ref_in;
            ref_sync_ff <= ref_meta_ff;
            ref_prev_ff <= ref_sync_ff;
            tick_ff     <= tick_source_select | ref_edge;
        end
    end

    assign tick = tick_ff;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sys_clock_tick_a : assert property (tick_source_select |=> tick)
        else $error("system clock selected but no tick");
    ref_only_edge_a : assert property (!tick_source_select && !ref_edge |=> !tick)
        else $error("reference tick without reference edge");

endmodule : tick_source

// file: verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import tick_timer_pkg::*;
    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext_ref_in;
    logic        awready, wready, bvalid, arready, rvalid, pend, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d, e;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    int          error_cnt, num_checks, n;

    system_tick_timer dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_ref_in(ext_ref_in),
        .tick_exception_pend(pend), .irq(irq)
    );

    always #20 aclk = ~aclk;

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic finish_test;
        if (error_cnt == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // both channels offered together; each released once its own ready is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er = RESP_OKAY, input logic [3:0] s = 4'hF);
        logic ad, wd;
        int   k;
        ad = 1'b0;
        wd = 1'b0;
        k = 0;
        awaddr <= a; wdata <= v; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!(ad && wd) && k < 50) begin
            @(posedge aclk);
            k++;
            if (!ad && awready === 1'b1) begin
                awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (!wd && wready === 1'b1) begin
                wvalid <= 1'b0;
                wd = 1'b1;
            end
        end
        do begin
            @(posedge aclk);
            k++;
        end while (bvalid !== 1'b1 && k < 50);
        check({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v,
                      input logic [1:0] er = RESP_OKAY);
        int k;
        k = 0;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
        end while (arready !== 1'b1 && k < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            k++;
        end while (rvalid !== 1'b1 && k < 50);
        v = rdata;
        check({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic wait_pend(input int lim);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (pend !== 1'b1 && n < lim);
    endtask : wait_pend

    // held high for two cycles so the synchroniser cannot miss it
    task automatic ref_pulse;
        ext_ref_in <= 1'b1;
        repeat (2) @(posedge aclk);
        ext_ref_in <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask : ref_pulse

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        check({31'h0, irq}, 32'h0);
        rd(OFF_CTRL, d); check(d, 32'h0);
        e = {2'b00, 6'h0, TEN_MS_COUNT};
        rd(OFF_CAL, d); check(d, e);
        rd(8'h40, d, RESP_SLVERR); check(d, 32'h0);
        wr(8'h40, 32'h1, RESP_SLVERR);
    endtask : t_reset

    task automatic t_fields;
        wr(OFF_RELOAD, 32'hFFFF_FFFF);
        rd(OFF_RELOAD, d); check(d, 32'h00FF_FFFF);
        wr(OFF_RELOAD, 32'h0000_0000, RESP_OKAY, 4'h1);
        rd(OFF_RELOAD, d); check(d, 32'h00FF_FF00);
        wr(OFF_CTRL, 32'hFFFE_FFF8);
        rd(OFF_CTRL, d); check(d, 32'h0);
        wr(OFF_CAL, 32'hFFFF_FFFF);
        rd(OFF_CAL, d); check(d, e);
    endtask : t_fields

    task automatic t_count;
        wr(OFF_RELOAD, 32'h3);
        wr(OFF_MASK, 32'h1);
        wr(OFF_CTRL, 32'h7);
        wait_pend(20); check(32'(n < 20), 32'h1);
        wait_pend(20); check(32'(n), 32'h4);
        wr(OFF_CTRL, 32'h6);
        rd(OFF_CTRL, d); check(d, 32'h0001_0006);
        rd(OFF_CTRL, d); check(d, 32'h0000_0006);
        check({31'h0, irq}, 32'h1);
        rd(OFF_EVT, d); check(d, 32'h1);
        wr(OFF_MASK, 32'h0); check({31'h0, irq}, 32'h0);
        wr(OFF_MASK, 32'h1); check({31'h0, irq}, 32'h1);
        wr(OFF_EVT, 32'h1); check({31'h0, irq}, 32'h0);
        rd(OFF_CUR, d); check(32'(d <= 32'h3), 32'h1);
        repeat (10) @(posedge aclk);
        rd(OFF_CUR, e); check(e, d);
    endtask : t_count

    task automatic t_clear;
        wr(OFF_CTRL, 32'h7);
        wait_pend(20); check(32'(n < 20), 32'h1);
        wr(OFF_CTRL, 32'h6);
        wr(OFF_CUR, 32'h1234_5678);
        rd(OFF_CUR, d); check(d, 32'h0);
        rd(OFF_CTRL, d); check(d, 32'h0000_0006);
        wr(OFF_EVT, 32'h1);
    endtask : t_clear

    task automatic t_no_int;
        wr(OFF_RELOAD, 32'h2);
        wr(OFF_CTRL, 32'h5);
        wait_pend(30); check(32'(n), 32'd30);
        wr(OFF_CTRL, 32'h4);
        rd(OFF_CTRL, d); check(d, 32'h0001_0004);
    endtask : t_no_int

    // external reference: no edges means no counting
    task automatic t_ext_ref;
        wr(OFF_CTRL, 32'h3);
        repeat (20) @(posedge aclk);
        rd(OFF_CUR, d); check(d, 32'h2);
        ref_pulse();
        rd(OFF_CUR, d); check(d, 32'h1);
        ref_pulse();
        rd(OFF_CUR, d); check(d, 32'h0);
        ref_pulse();
        rd(OFF_CUR, d); check(d, 32'h2);
        rd(OFF_CTRL, d); check(d, 32'h0001_0003);
        wr(OFF_CTRL, 32'h0);
    endtask : t_ext_ref

    // one full TEN_MS_COUNT-tick period on the system clock with the advised reload
    task automatic t_periodic;
        wr(OFF_RELOAD, {8'h00, TEN_MS_COUNT - 24'h00_0001});
        wr(OFF_CTRL, 32'h7);
        wait_pend(4000); check(32'(n < 4000), 32'h1);
        wait_pend(4000); check(32'(n), 32'(TEN_MS_COUNT));
        wr(OFF_CTRL, 32'h0);
        wr(OFF_EVT, 32'h1);
    endtask : t_periodic

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        aclk = 1'b0; aresetn = 1'b0; ext_ref_in = 1'b0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
        error_cnt = 0;
        num_checks = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_fields();
        t_count();
        t_clear();
        t_no_int();
        t_ext_ref();
        t_periodic();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        finish_test();
    end
endmodule : tb_top
